// *** hw/tcc_timer.sv ***
/*
 * two channel capture/compare timer with prescaled 16-bit modulo counter,
 * axi4-lite register slave and channel pin drivers.
 * assumes one clock (aclk), synchronous active-low reset, asynchronous pins.
 */
`timescale 1ns/1ns
// Operation
// R01 - two channels, each capture or compare
// R02 - prescaler picks one of seven rates
// R03 - active pin edge captures counter value; code ignores edges while the counter is stopped
// R04 - every capture overwrites, flag state ignored
// R05 - captured value lands two cycles later
// R06 - set flag raises enabled interrupt request
// R07 - reset leaves channel values untouched
// R08 - all channels share one modulo counter
// R09 - compare match sets, clears or toggles
// R10 - unbuffered writes take effect at once
// R11 - link bit pairs channels onto pin0
// R12 - last written set takes over at overflow
// R13 - linked: channel1 control unused, pin1 released
// R14 - toggle on overflow forms pwm period
// R15 - pulse runs overflow to compare match
// R16 - modulo ff gives 256 cycle period
// R17 - buffered write applies next pwm period
// R18 - software writes only the inactive set
// R19 - software times unbuffered value changes
// R20 - software avoids toggle on compare
// R21 - counter at modulo sets overflow flag
// R22 - mode and edge encodings as documented
// R23 - zero and full duty outputs
// R24 - counter wraps to zero after modulo
module tcc_timer #(
    parameter int AW = tcc_pkg::ADDR_W
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic [1:0]    chan_pin_in,
    output logic      [1:0]    chan_pin_out,
    output logic      [1:0]    chan_pin_oe,
    output logic               timer_irq
);
    function automatic logic [2:0] reg_index(input logic [AW-1:0] a);
        logic [2:0] idx;
        idx = tcc_pkg::IDX_NONE;
        case (a)
            AW'(tcc_pkg::OFF_CTRL):     idx = tcc_pkg::IDX_CTRL;
            AW'(tcc_pkg::OFF_COUNT):    idx = tcc_pkg::IDX_COUNT;
            AW'(tcc_pkg::OFF_MODULO):   idx = tcc_pkg::IDX_MODULO;
            AW'(tcc_pkg::OFF_CH0_CTRL): idx = tcc_pkg::IDX_CH0_CTRL;
            AW'(tcc_pkg::OFF_CH0_VAL):  idx = tcc_pkg::IDX_CH0_VAL;
            AW'(tcc_pkg::OFF_CH1_CTRL): idx = tcc_pkg::IDX_CH1_CTRL;
            AW'(tcc_pkg::OFF_CH1_VAL):  idx = tcc_pkg::IDX_CH1_VAL;
            default:                    idx = tcc_pkg::IDX_NONE;
        endcase
        return idx;
    endfunction

    localparam int PRE_W = tcc_pkg::PRE_W;

    // bus slave state
    logic [AW-1:0] awaddr_ff;
    logic [31:0]   wdata_ff;
    logic [3:0]    wstrb_ff;
    logic [AW-1:0] araddr_ff;
    logic          rd_pend_ff;
    logic          wr_go;
    logic          rd_go;
    logic [2:0]    wr_idx;
    logic [2:0]    rd_idx;
    logic [31:0]   nxt_rdata;

    // timer state
    logic             ovf_flag_ff;
    logic             ovf_arm_ff;
    logic             ovf_ie_ff;
    logic             stop_ff;
    logic [2:0]       ps_ff;
    logic [PRE_W-1:0] pre_ff;
    logic [15:0]      cnt_ff;
    logic [15:0]      modulo_ff;
    logic             cnt_step_ff;
    logic             cnt_rst_wr;
    logic [PRE_W-1:0] ps_mask;
    logic             tick;
    logic             ovf_evt;
    logic             wrap_evt;

    // channel state
    logic [1:0]  ch_flag_ff;
    logic [1:0]  ch_arm_ff;
    logic [1:0]  ch_ie_ff;
    logic [1:0]  ch_mode_ff [2];
    logic [1:0]  ch_els_ff  [2];
    logic [1:0]  ch_tov_ff;
    logic [1:0]  ch_max_ff;
    logic [15:0] ch_val_ff  [2];
    logic [1:0]  ch_ctrl_wr;
    logic [1:0]  ch_val_wr;
    logic [1:0]  cap_evt;
    logic [1:0]  cmp_evt;
    logic [1:0]  pin_sync;
    logic [7:0]  ch_ctrl_rd [2];
    logic        link;
    logic        act_ff;
    logic        last_wr_ff;
    logic        nxt_last_wr;
    logic [15:0] cmp0_value;

    // write channel: address and data may arrive in either order
    assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_idx = reg_index(awaddr_ff);
    assign rd_go  = rd_pend_ff;
    assign rd_idx = reg_index(araddr_ff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= tcc_pkg::RESP_OKAY;
            awaddr_ff     <= '0;
            wdata_ff      <= '0;
            wstrb_ff      <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awaddr_ff     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_idx == tcc_pkg::IDX_NONE) ? tcc_pkg::RESP_SLVERR : tcc_pkg::RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= tcc_pkg::RESP_OKAY;
            araddr_ff     <= '0;
            rd_pend_ff    <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                araddr_ff     <= s_axi_araddr;
                rd_pend_ff    <= 1'b1;
            end
            if (rd_go) begin
                rd_pend_ff   <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= nxt_rdata;
                s_axi_rresp  <= (rd_idx == tcc_pkg::IDX_NONE) ? tcc_pkg::RESP_SLVERR : tcc_pkg::RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    always_comb begin
        nxt_rdata = '0;
        case (rd_idx)
            tcc_pkg::IDX_CTRL: begin
                nxt_rdata[tcc_pkg::CTRL_OVF_FLAG] = ovf_flag_ff;
                nxt_rdata[tcc_pkg::CTRL_OVF_IE]   = ovf_ie_ff;
                nxt_rdata[tcc_pkg::CTRL_STOP]     = stop_ff;
                nxt_rdata[tcc_pkg::CTRL_PS_LSB +: tcc_pkg::PS_W] = ps_ff;
            end
            tcc_pkg::IDX_COUNT:    nxt_rdata[15:0] = cnt_ff;
            tcc_pkg::IDX_MODULO:   nxt_rdata[15:0] = modulo_ff;
            tcc_pkg::IDX_CH0_CTRL: nxt_rdata[7:0]  = ch_ctrl_rd[0];
            tcc_pkg::IDX_CH0_VAL:  nxt_rdata[15:0] = ch_val_ff[0];
            tcc_pkg::IDX_CH1_CTRL: nxt_rdata[7:0]  = ch_ctrl_rd[1];
            tcc_pkg::IDX_CH1_VAL:  nxt_rdata[15:0] = ch_val_ff[1];
            default:               nxt_rdata = '0;
        endcase
    end

    // R02 seven prescaler rates
    assign ps_mask    = (ps_ff > tcc_pkg::PS_MAX) ? ~PRE_W'(0) : PRE_W'((7'h01 << ps_ff) - 7'h01);
    assign tick       = ((pre_ff & ps_mask) == ps_mask);
    assign cnt_rst_wr = wr_go && (wr_idx == tcc_pkg::IDX_CTRL) && wstrb_ff[0] && wdata_ff[tcc_pkg::CTRL_CNT_RST];
    // R21 counter reaches modulo
    assign ovf_evt    = cnt_step_ff && (cnt_ff == modulo_ff);
    // R14 pin toggles on wrap
    // acting on the wrap, not on modulo itself, makes the pulse width equal the compare value
    assign wrap_evt   = cnt_step_ff && (cnt_ff == 16'h0000);

    // R08 one shared counter
    always_ff @(posedge aclk) begin
        if (!aresetn || cnt_rst_wr) begin
            pre_ff      <= '0;
            cnt_ff      <= '0;
            cnt_step_ff <= 1'b0;
        end else begin
            cnt_step_ff <= !stop_ff && tick;
            if (!stop_ff) begin
                pre_ff <= pre_ff + PRE_W'(1);
                if (tick) begin
                    // R24 wrap after modulo
                    // R16 period is modulo plus one
                    cnt_ff <= (cnt_ff == modulo_ff) ? 16'h0000 : cnt_ff + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_ie_ff <= 1'b0;
            stop_ff   <= tcc_pkg::STOP_RST;
            ps_ff     <= tcc_pkg::PS_RST;
            modulo_ff <= tcc_pkg::MODULO_RST;
        end else if (wr_go) begin
            if (wr_idx == tcc_pkg::IDX_CTRL && wstrb_ff[0]) begin
                ovf_ie_ff <= wdata_ff[tcc_pkg::CTRL_OVF_IE];
                stop_ff   <= wdata_ff[tcc_pkg::CTRL_STOP];
                ps_ff     <= wdata_ff[tcc_pkg::CTRL_PS_LSB +: tcc_pkg::PS_W];
            end
            if (wr_idx == tcc_pkg::IDX_MODULO) begin
                if (wstrb_ff[0]) modulo_ff[7:0]  <= wdata_ff[7:0];
                if (wstrb_ff[1]) modulo_ff[15:8] <= wdata_ff[15:8];
            end
        end
    end

    // overflow flag: clear needs a read with the flag set, then a zero write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_flag_ff <= 1'b0;
            ovf_arm_ff  <= 1'b0;
        end else begin
            if (rd_go && rd_idx == tcc_pkg::IDX_CTRL && ovf_flag_ff) begin
                ovf_arm_ff <= 1'b1;
            end
            if (wr_go && wr_idx == tcc_pkg::IDX_CTRL && wstrb_ff[0]) begin
                ovf_arm_ff <= 1'b0;
                if (ovf_arm_ff && !wdata_ff[tcc_pkg::CTRL_OVF_FLAG]) begin
                    ovf_flag_ff <= 1'b0;
                end
            end
            // R21 set beats clear
            if (ovf_evt) begin
                ovf_flag_ff <= 1'b1;
                ovf_arm_ff  <= 1'b0;
            end
        end
    end

    // R11 link bit on channel 0
    assign link = ch_mode_ff[0][1];
    assign nxt_last_wr = ch_val_wr[1] ? 1'b1 : (ch_val_wr[0] ? 1'b0 : last_wr_ff);
    // R17 inactive set applies next period
    assign cmp0_value = link ? ch_val_ff[act_ff] : ch_val_ff[0];

    // R12 swap at overflow
    always_ff @(posedge aclk) begin
        if (!aresetn || !link) begin
            act_ff     <= 1'b0;
            last_wr_ff <= 1'b0;
        end else begin
            last_wr_ff <= nxt_last_wr;
            if (ovf_evt) begin
                act_ff <= nxt_last_wr;
            end
        end
    end

    tcc_sync #(
        .W (2)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (chan_pin_in),
        .sync_out (pin_sync)
    );

    // R01 two channels, independent unless the link bit on channel 0 is set
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_ch
            localparam logic [2:0] CTRL_IDX = (g == 0) ? tcc_pkg::IDX_CH0_CTRL : tcc_pkg::IDX_CH1_CTRL;
            localparam logic [2:0] VAL_IDX  = (g == 0) ? tcc_pkg::IDX_CH0_VAL : tcc_pkg::IDX_CH1_VAL;

            assign ch_ctrl_wr[g] = wr_go && (wr_idx == CTRL_IDX) && wstrb_ff[0];
            assign ch_val_wr[g]  = wr_go && (wr_idx == VAL_IDX) && (wstrb_ff[1:0] != 2'b00);
            assign ch_ctrl_rd[g] = {ch_flag_ff[g], ch_ie_ff[g], ch_mode_ff[g], ch_els_ff[g],
                                    ch_tov_ff[g], ch_max_ff[g]};

            // R22 mode and edge fields
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ch_ie_ff[g]   <= 1'b0;
                    ch_mode_ff[g] <= tcc_pkg::MODE_CAPTURE;
                    ch_els_ff[g]  <= tcc_pkg::ELS_OFF;
                    ch_tov_ff[g]  <= 1'b0;
                    ch_max_ff[g]  <= 1'b0;
                end else if (ch_ctrl_wr[g]) begin
                    ch_ie_ff[g]   <= wdata_ff[tcc_pkg::CH_IE];
                    // buffered link exists only on channel 0
                    ch_mode_ff[g] <= {(g == 0) && wdata_ff[tcc_pkg::CH_MS_HIGH], wdata_ff[tcc_pkg::CH_MS_LOW]};
                    ch_els_ff[g]  <= {wdata_ff[tcc_pkg::CH_ELS_HIGH], wdata_ff[tcc_pkg::CH_ELS_LOW]};
                    ch_tov_ff[g]  <= wdata_ff[tcc_pkg::CH_TOV];
                    ch_max_ff[g]  <= wdata_ff[tcc_pkg::CH_MAX];
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ch_flag_ff[g] <= 1'b0;
                    ch_arm_ff[g]  <= 1'b0;
                end else begin
                    if (rd_go && rd_idx == CTRL_IDX && ch_flag_ff[g]) begin
                        ch_arm_ff[g] <= 1'b1;
                    end
                    if (ch_ctrl_wr[g]) begin
                        ch_arm_ff[g] <= 1'b0;
                        if (ch_arm_ff[g] && !wdata_ff[tcc_pkg::CH_FLAG]) begin
                            ch_flag_ff[g] <= 1'b0;
                        end
                    end
                    // R06 flag set beats clear
                    if (cap_evt[g] || cmp_evt[g]) begin
                        ch_flag_ff[g] <= 1'b1;
                        ch_arm_ff[g]  <= 1'b0;
                    end
                end
            end

            // R07 no reset on values
            always_ff @(posedge aclk) begin
                if (cap_evt[g]) begin
                    // R04 capture always overwrites
                    // R05 two-stage sync then latch
                    ch_val_ff[g] <= cnt_ff;
                end else if (wr_go && wr_idx == VAL_IDX) begin
                    // R10 unbuffered write is immediate
                    if (wstrb_ff[0]) ch_val_ff[g][7:0]  <= wdata_ff[7:0];
                    if (wstrb_ff[1]) ch_val_ff[g][15:8] <= wdata_ff[15:8];
                end
            end

            // R13 channel 1 idle while linked
            tcc_channel u_channel (
                .aclk          (aclk),
                .aresetn       (aresetn),
                .mode          (ch_mode_ff[g]),
                .els           (ch_els_ff[g]),
                .tov           (ch_tov_ff[g]),
                .max_duty      (ch_max_ff[g]),
                .capture_allow (!stop_ff && !((g == 1) && link)),
                .cmp_enable    (!((g == 1) && link)),
                .pin_sync      (pin_sync[g]),
                .cnt_step      (cnt_step_ff),
                .ovf_evt       (wrap_evt),
                .count         (cnt_ff),
                .cmp_value     ((g == 0) ? cmp0_value : ch_val_ff[g]),
                .capture_evt   (cap_evt[g]),
                .compare_evt   (cmp_evt[g]),
                .pin_out       (chan_pin_out[g])
            );

            // R13 release pin 1 when linked
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    chan_pin_oe[g] <= 1'b0;
                end else begin
                    chan_pin_oe[g] <= (ch_mode_ff[g] != tcc_pkg::MODE_CAPTURE) && (ch_els_ff[g] != tcc_pkg::ELS_OFF)
                                      && !((g == 1) && link);
                end
            end
        end
    endgenerate

    // R06 interrupt request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= (ovf_flag_ff && ovf_ie_ff) || ((ch_flag_ff & ch_ie_ff) != 2'b00);
        end
    end
endmodule

// *** hw/tcc_pkg.sv ***
/*
 * constants for the two channel capture/compare timer: register byte offsets,
 * field positions, reset values and mode encodings.
 * assumes an axi4-lite slave with 32-bit data, one register per aligned word.
 */
package tcc_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          CNT_W           = 16;
    localparam int          PRE_W           = 6;
    localparam int          SYNC_STAGES     = 2;

    localparam logic [7:0]  OFF_CTRL        = 8'h00;
    localparam logic [7:0]  OFF_COUNT       = 8'h04;
    localparam logic [7:0]  OFF_MODULO      = 8'h08;
    localparam logic [7:0]  OFF_CH0_CTRL    = 8'h0c;
    localparam logic [7:0]  OFF_CH0_VAL     = 8'h10;
    localparam logic [7:0]  OFF_CH1_CTRL    = 8'h14;
    localparam logic [7:0]  OFF_CH1_VAL     = 8'h18;

    localparam logic [2:0]  IDX_CTRL        = 3'h0;
    localparam logic [2:0]  IDX_COUNT       = 3'h1;
    localparam logic [2:0]  IDX_MODULO      = 3'h2;
    localparam logic [2:0]  IDX_CH0_CTRL    = 3'h3;
    localparam logic [2:0]  IDX_CH0_VAL     = 3'h4;
    localparam logic [2:0]  IDX_CH1_CTRL    = 3'h5;
    localparam logic [2:0]  IDX_CH1_VAL     = 3'h6;
    localparam logic [2:0]  IDX_NONE        = 3'h7;

    localparam int          CTRL_OVF_FLAG   = 7;
    localparam int          CTRL_OVF_IE     = 6;
    localparam int          CTRL_STOP       = 5;
    localparam int          CTRL_CNT_RST    = 4;
    localparam int          CTRL_PS_LSB     = 0;
    localparam int          PS_W            = 3;
    localparam logic [2:0]  PS_MAX          = 3'h6;

    localparam int          CH_FLAG         = 7;
    localparam int          CH_IE           = 6;
    localparam int          CH_MS_HIGH      = 5;
    localparam int          CH_MS_LOW       = 4;
    localparam int          CH_ELS_HIGH     = 3;
    localparam int          CH_ELS_LOW      = 2;
    localparam int          CH_TOV          = 1;
    localparam int          CH_MAX          = 0;

    localparam logic        STOP_RST        = 1'b1;
    localparam logic [2:0]  PS_RST          = 3'h0;
    localparam logic [15:0] MODULO_RST      = 16'hffff;

    localparam logic [1:0]  ELS_OFF         = 2'h0;
    localparam logic [1:0]  ELS_TOGGLE      = 2'h1;
    localparam logic [1:0]  ELS_CLEAR       = 2'h2;
    localparam logic [1:0]  ELS_SET         = 2'h3;

    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    typedef enum logic [1:0] {
        MODE_CAPTURE  = 2'b00,
        MODE_COMPARE  = 2'b01,
        MODE_BUFFERED = 2'b10,
        MODE_BUF_ALT  = 2'b11
    } tcc_mode_e;
endpackage

// *** hw/tcc_sync.sv ***
/*
 * two-flop synchroniser for the channel pins.
 * assumes inputs are asynchronous to aclk; only the last stage is read outside.
 */
`timescale 1ns/1ns
module tcc_sync #(
    parameter int W = 2
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// *** hw/tcc_channel.sv ***
/*
 * one timer channel: edge detect for capture, compare match and pin action.
 * assumes a synchronised pin level and a counter step pulse from the top.
 */
`timescale 1ns/1ns
module tcc_channel (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [1:0]  mode,
    input  wire logic [1:0]  els,
    input  wire logic        tov,
    input  wire logic        max_duty,
    input  wire logic        capture_allow,
    input  wire logic        cmp_enable,
    input  wire logic        pin_sync,
    input  wire logic        cnt_step,
    input  wire logic        ovf_evt,
    input  wire logic [15:0] count,
    input  wire logic [15:0] cmp_value,
    output logic             capture_evt,
    output logic             compare_evt,
    output logic             pin_out
);
    logic pin_prev_ff;
    logic is_capture;
    logic is_output;
    logic rise;
    logic fall;

    assign is_capture = (mode == tcc_pkg::MODE_CAPTURE);
    assign is_output  = !is_capture && cmp_enable;
    assign rise       = pin_sync && !pin_prev_ff;
    assign fall       = !pin_sync && pin_prev_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_prev_ff <= 1'b0;
        end else begin
            pin_prev_ff <= pin_sync;
        end
    end

    // R03 edge select
    assign capture_evt = is_capture && capture_allow && ((els[0] && rise) || (els[1] && fall));

    // R09 compare match
    assign compare_evt = is_output && cnt_step && (count == cmp_value);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= 1'b0;
        end else if (is_output) begin
            // R14 toggle on overflow
            if (ovf_evt && tov) begin
                // R23 full or zero duty forcing
                if (max_duty) begin
                    pin_out <= !els[0];
                end else begin
                    pin_out <= !pin_out;
                end
            end
            // R15 compare ends pulse
            if (compare_evt && !(tov && max_duty)) begin
                case (els)
                    tcc_pkg::ELS_TOGGLE: pin_out <= !pin_out;
                    tcc_pkg::ELS_CLEAR:  pin_out <= 1'b0;
                    tcc_pkg::ELS_SET:    pin_out <= 1'b1;
                    default:             pin_out <= pin_out;
                endcase
            end
        end
    end
endmodule

// *** verif/tcc_properties.sv ***
/* checker: register bus answer timing of tcc_timer.
   assumes bind onto tcc_timer, one clock, synchronous reset. */
`timescale 1ns/1ns
module tcc_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // readies drop at once, so a second request cannot slip in before the answer
    sequence wr_answer; !s_axi_awready ##1 s_axi_bvalid; endsequence
    sequence rd_answer; !s_axi_arready ##1 s_axi_rvalid; endsequence
    chk_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready |=> wr_answer)
        else $error("write answer late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> rd_answer)
        else $error("read answer late");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |-> s_axi_bvalid [*2])
        else $error("bvalid dropped");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
    chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    chk_write_done: assert property (s_axi_bvalid && s_axi_bready |=> $fell(s_axi_bvalid) && s_axi_awready)
        else $error("write not released");
    chk_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not released");
endmodule
bind tcc_timer tcc_properties chk (.*);

// *** verif/tcc_pin_model.sv ***
/* pin partner: outside drivers on both channel pins.
   assumes the timer's drive value and enable per pin. */
`timescale 1ns/1ns
module tcc_pin_model (
    input  wire logic [1:0] ext_en,
    input  wire logic [1:0] ext_lvl,
    input  wire logic [1:0] chan_pin_out,
    input  wire logic [1:0] chan_pin_oe,
    output logic      [1:0] chan_pin_in
);
    // edge source; a free pin is pulled up
    assign chan_pin_in = (chan_pin_oe & chan_pin_out) | (~chan_pin_oe & (~ext_en | ext_lvl));
endmodule

// *** verif/tcc_timer_tb_top.sv ***
/* bench: bus task, capture and pwm checks at the pins.
   assumes tcc_pin_model and the bound checker. */
`timescale 1ns/1ns
module tcc_timer_tb_top;
    logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, timer_irq;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv, c1, cv;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsv, chan_pin_in, chan_pin_out, chan_pin_oe, ext_lvl = 2'h0, ext_en = 2'h1;
    int          n_mismatch = 0, total_checks = 0, hi, per;
    tcc_timer DUT (.*);
    tcc_pin_model pins (.*);
    always #25 aclk = ~aclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %0t: %h %h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // each channel released on its own ready; answer held a cycle before taking it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_bvalid && !s_axi_rvalid);
        {s_axi_bready, s_axi_rready} <= {w, !w};
        @(posedge aclk);
        {s_axi_bready, s_axi_rready} <= 2'h0;
        {rdv, rsv} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
    endtask
    // cycles from one rise of the pin to the next, and how many of them high
    task automatic pwm(input int ch);
        logic lv = 1'h1;
        int   n = 0;
        hi = 0;
        per = 0;
        while (n < 2) begin
            @(posedge aclk);
            n += int'(chan_pin_out[ch] && !lv);
            if (n == 1) begin
                per++;
                hi += int'(chan_pin_out[ch]);
            end
            lv = chan_pin_out[ch];
        end
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        xfer(0, 8'h1c, 32'h0);
        chk(32'(rsv), 32'h2);
        xfer(1, 8'h0c, 32'h44);
        chk(32'(rsv), 32'h0);
        xfer(1, 8'h00, 32'h06);
        repeat (70) @(posedge aclk);
        xfer(0, 8'h04, 32'h0);
        c1 = rdv;
        ext_lvl <= 2'h1;
        repeat (4) @(posedge aclk);
        xfer(0, 8'h10, 32'h0);
        cv = rdv;
        xfer(0, 8'h04, 32'h0);
        chk(32'(c1 > 0 && cv >= c1 && cv <= rdv), 32'h1);
        xfer(0, 8'h0c, 32'h0);
        chk(rdv, 32'hc4);
        chk(32'(timer_irq), 32'h1);
        ext_en <= 2'h0;
        xfer(1, 8'h08, 32'hff);
        xfer(1, 8'h00, 32'h10);
        xfer(1, 8'h18, 32'h80);
        xfer(1, 8'h14, 32'h1a);
        pwm(1);
        chk(per, 256);
        chk(hi, 128);
        xfer(1, 8'h10, 32'h40);
        xfer(1, 8'h0c, 32'h2a);
        pwm(0);
        chk(hi, 64);
        chk(32'(chan_pin_oe), 32'h1);
        xfer(1, 8'h18, 32'h20);
        pwm(0);
        chk(hi, 32);
        xfer(0, 8'h00, 32'h0);
        chk(rdv, 32'h80);
        complete_run();
    end
    initial begin
        repeat (10000) @(posedge aclk);
        n_mismatch++;
        complete_run();
    end
endmodule
